// ---- hdl/oag_pkg.sv ----
// Purpose: Shared constants and types of the operand address generator
// Assumes: Register and segment codes come from the instruction decoder
// Notes:   Codes below are this block's own encoding
`default_nettype none
package oag_pkg;
	localparam int ADDR_W   = 32;
	localparam int SEL_W    = 16;
	localparam int FAR_W    = 48;
	localparam int QUAD_W   = 64;
	localparam int DISP8_W  = 8;
	localparam int DISP16_W = 16;
	localparam int FAR_SEL_LSB = 32;

	// General-purpose register numbers
	typedef enum logic [2:0] {
		OAG_GPR_ACC   = 3'h0,
		OAG_GPR_CNT   = 3'h1,
		OAG_GPR_DHI   = 3'h2,
		OAG_GPR_BASE  = 3'h3,
		OAG_GPR_STACK = 3'h4,
		OAG_GPR_FRAME = 3'h5,
		OAG_GPR_SRC   = 3'h6,
		OAG_GPR_DST   = 3'h7
	} oag_gpr_t;

	typedef enum logic [2:0] {
		OAG_SEG_STRING_TARGET = 3'h0,
		OAG_SEG_CODE          = 3'h1,
		OAG_SEG_STACK         = 3'h2,
		OAG_SEG_DATA          = 3'h3,
		OAG_SEG_AUX0          = 3'h4,
		OAG_SEG_AUX1          = 3'h5
	} oag_seg_t;

	// Kind of memory reference being addressed
	typedef enum logic [1:0] {
		OAG_REF_DATA     = 2'h0,
		OAG_REF_FETCH    = 2'h1,
		OAG_REF_PUSHPOP  = 2'h2,
		OAG_REF_STR_DEST = 2'h3
	} oag_ref_t;

	typedef enum logic [1:0] {
		OAG_DISP_8  = 2'h0,
		OAG_DISP_16 = 2'h1,
		OAG_DISP_32 = 2'h2
	} oag_disp_t;

	// Index multiplier as a left shift
	typedef enum logic [1:0] {
		OAG_SCALE_1 = 2'h0,
		OAG_SCALE_2 = 2'h1,
		OAG_SCALE_4 = 2'h2,
		OAG_SCALE_8 = 2'h3
	} oag_scale_t;
endpackage : oag_pkg
`default_nettype wire

// ---- hdl/oag_addr_if.sv ----
// Purpose: Carries address components between the generator and its helpers
// Assumes: All signals combinational within one cycle
// Notes:   One modport per helper, one for the owner
`timescale 1ns/1ps
`default_nettype none
interface oag_addr_if;
	import oag_pkg::*;
	logic                base_en;
	oag_gpr_t            base_id;
	logic [ADDR_W-1:0]   base_val;
	logic                index_en;
	oag_gpr_t            index_id;
	logic [ADDR_W-1:0]   index_val;
	oag_scale_t          scale;
	logic                disp_en;
	oag_disp_t           disp_w;
	logic [ADDR_W-1:0]   disp_val;
	logic [ADDR_W-1:0]   ea;
	logic                index_bad;
	oag_ref_t            ref_kind;
	logic                ovr_en;
	oag_seg_t            ovr_seg;
	oag_seg_t            seg;

	modport owner (output base_en, base_id, base_val, index_en, index_id, index_val, scale,
		disp_en, disp_w, disp_val, ref_kind, ovr_en, ovr_seg, input ea, index_bad, seg);
	modport adder (input base_en, base_val, index_en, index_id, index_val, scale,
		disp_en, disp_w, disp_val, output ea, index_bad);
	modport selector (input base_en, base_id, ref_kind, ovr_en, ovr_seg, output seg);
endinterface : oag_addr_if
`default_nettype wire

// ---- hdl/oag_ea_adder.sv ----
// Purpose: Effective address sum of displacement, base and scaled index
// Assumes: Absent components are flagged by their enables
// Notes:   Purely combinational, wraps at 32 bits
`timescale 1ns/1ps
`default_nettype none
module oag_ea_adder
	import oag_pkg::*;
(
	oag_addr_if.adder a
);
	logic [ADDR_W-1:0] disp_sx;
	logic [ADDR_W-1:0] base_term;
	logic [ADDR_W-1:0] index_term;

	always_comb begin
		disp_sx = '0;
		if (a.disp_en) begin
			unique case (a.disp_w)
				OAG_DISP_8:  disp_sx = {{(ADDR_W-DISP8_W){a.disp_val[DISP8_W-1]}},
					a.disp_val[DISP8_W-1:0]};
				OAG_DISP_16: disp_sx = {{(ADDR_W-DISP16_W){a.disp_val[DISP16_W-1]}},
					a.disp_val[DISP16_W-1:0]};
				default:     disp_sx = a.disp_val;
			endcase
		end
	end

	// Stack pointer is never an index
	assign a.index_bad = a.index_en && (a.index_id == OAG_GPR_STACK);
	assign base_term   = a.base_en ? a.base_val : '0;
	// Scale only touches a present, legal index
	assign index_term  = (a.index_en && !a.index_bad) ?
		(a.index_val << a.scale) : '0;
	// Carry out of bit 31 is dropped
	assign a.ea = disp_sx + base_term + index_term;
endmodule : oag_ea_adder
`default_nettype wire

// ---- hdl/oag_seg_select.sv ----
// Purpose: Default segment choice and override filtering
// Assumes: Override prefix already decoded into a segment code
// Notes:   Fetch, push/pop and string destination ignore overrides
`timescale 1ns/1ps
`default_nettype none
module oag_seg_select
	import oag_pkg::*;
(
	oag_addr_if.selector s
);
	logic stack_based;

	assign stack_based = s.base_en &&
		(s.base_id == OAG_GPR_STACK || s.base_id == OAG_GPR_FRAME);

	always_comb begin
		unique case (s.ref_kind)
			OAG_REF_FETCH:    s.seg = OAG_SEG_CODE;
			OAG_REF_PUSHPOP:  s.seg = OAG_SEG_STACK;
			OAG_REF_STR_DEST: s.seg = OAG_SEG_STRING_TARGET;
			default: begin
				if (s.ovr_en)
					s.seg = s.ovr_seg;
				else if (stack_based)
					s.seg = OAG_SEG_STACK;
				else
					s.seg = OAG_SEG_DATA;
			end
		endcase
	end
endmodule : oag_seg_select
`default_nettype wire

// ---- hdl/oag_top.sv ----
// Purpose: Operand address generator between decoder and memory stage
// Assumes: Decoder inputs synchronous to i_clk, one request per cycle
// Notes:   All results but the byte addresses registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module oag_top
	import oag_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	input  wire logic              i_req_valid,
	input  wire oag_ref_t          i_ref_kind,
	input  wire logic              i_base_en,
	input  wire oag_gpr_t          i_base_id,
	input  wire logic [ADDR_W-1:0] i_base_val,
	input  wire logic              i_index_en,
	input  wire oag_gpr_t          i_index_id,
	input  wire logic [ADDR_W-1:0] i_index_val,
	input  wire oag_scale_t        i_scale,
	input  wire logic              i_disp_en,
	input  wire oag_disp_t         i_disp_w,
	input  wire logic [ADDR_W-1:0] i_disp_val,
	input  wire logic              i_ovr_en,
	input  wire oag_seg_t          i_ovr_seg,
	input  wire logic [ADDR_W-1:0] i_store_data,
	input  wire logic              i_sel_load,
	input  wire logic              i_sel_from_reg,
	input  wire logic [SEL_W-1:0]  i_sel_mem,
	input  wire logic [SEL_W-1:0]  i_sel_reg,
	input  wire oag_seg_t          i_sel_target,
	input  wire logic              i_far_valid,
	input  wire logic [FAR_W-1:0]  i_far_mem,
	input  wire logic [ADDR_W-1:0] i_data_high_reg,
	input  wire logic [ADDR_W-1:0] i_accumulator_reg,
	input  wire logic [QUAD_W-1:0] i_quad_result,
	input  wire logic              i_imm_valid,
	input  wire logic              i_quotient_op,
	output logic                   o_valid,
	output logic [ADDR_W-1:0]      o_ea,
	output oag_seg_t               o_seg,
	output logic                   o_index_fault,
	output logic [ADDR_W-1:0]      o_byte_addr [4],
	output logic [7:0]             o_byte_data [4],
	output logic                   o_sel_valid,
	output oag_seg_t               o_sel_target,
	output logic [SEL_W-1:0]       o_sel_value,
	output logic                   o_far_valid,
	output logic [ADDR_W-1:0]      o_far_offset,
	output logic [SEL_W-1:0]       o_far_selector,
	output logic [QUAD_W-1:0]      o_quad_operand,
	output logic [ADDR_W-1:0]      o_quad_high,
	output logic [ADDR_W-1:0]      o_quad_low,
	output logic                   o_imm_refused
);
	////////////////////////////////////////////////////////////////////////////
	oag_addr_if ai ();

	assign ai.base_en   = i_base_en;
	assign ai.base_id   = i_base_id;
	assign ai.base_val  = i_base_val;
	assign ai.index_en  = i_index_en;
	assign ai.index_id  = i_index_id;
	assign ai.index_val = i_index_val;
	assign ai.scale     = i_scale;
	assign ai.disp_en   = i_disp_en;
	assign ai.disp_w    = i_disp_w;
	assign ai.disp_val  = i_disp_val;
	assign ai.ref_kind  = i_ref_kind;
	assign ai.ovr_en    = i_ovr_en;
	assign ai.ovr_seg   = i_ovr_seg;

	oag_ea_adder   u_adder (.a(ai.adder));
	oag_seg_select u_segsel (.s(ai.selector));

	////////////////////////////////////////////////////////////////////////////
	logic                  valid_r;
	logic [ADDR_W-1:0]     ea_r;
	oag_seg_t              seg_r;
	logic                  index_fault_r;
	logic [ADDR_W-1:0]     store_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			valid_r       <= 1'b0;
			ea_r          <= '0;
			seg_r         <= OAG_SEG_DATA;
			index_fault_r <= 1'b0;
			store_r       <= '0;
		end else begin
			valid_r       <= i_req_valid;
			index_fault_r <= i_req_valid && ai.index_bad;
			if (i_req_valid) begin
				ea_r    <= ai.ea;
				seg_r   <= ai.seg;
				store_r <= i_store_data;
			end
		end
	end

	assign o_valid       = valid_r;
	assign o_ea          = ea_r;
	assign o_seg         = seg_r;
	assign o_index_fault = index_fault_r;

	// Byte k of the operand sits at address ea+k
	for (genvar k = 0; k < 4; k++) begin : g_lane
		assign o_byte_addr[k] = ea_r + ADDR_W'(k);
		assign o_byte_data[k] = store_r[8*k +: 8];
	end

	////////////////////////////////////////////////////////////////////////////
	logic                  sel_valid_r;
	oag_seg_t              sel_target_r;
	logic [SEL_W-1:0]      sel_value_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sel_valid_r  <= 1'b0;
			sel_target_r <= OAG_SEG_DATA;
			sel_value_r  <= '0;
		end else begin
			sel_valid_r <= i_sel_load;
			if (i_sel_load) begin
				sel_target_r <= i_sel_target;
				sel_value_r  <= i_sel_from_reg ? i_sel_reg : i_sel_mem;
			end
		end
	end

	assign o_sel_valid  = sel_valid_r;
	assign o_sel_target = sel_target_r;
	assign o_sel_value  = sel_value_r;

	////////////////////////////////////////////////////////////////////////////
	logic                  far_valid_r;
	logic [ADDR_W-1:0]     far_off_r;
	logic [SEL_W-1:0]      far_sel_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			far_valid_r <= 1'b0;
			far_off_r   <= '0;
			far_sel_r   <= '0;
		end else begin
			far_valid_r <= i_far_valid;
			if (i_far_valid) begin
				far_off_r <= i_far_mem[ADDR_W-1:0];
				far_sel_r <= i_far_mem[FAR_W-1:FAR_SEL_LSB];
			end
		end
	end

	assign o_far_valid    = far_valid_r;
	assign o_far_offset   = far_off_r;
	assign o_far_selector = far_sel_r;

	////////////////////////////////////////////////////////////////////////////
	logic [QUAD_W-1:0]     quad_r;
	logic [ADDR_W-1:0]     qhigh_r;
	logic [ADDR_W-1:0]     qlow_r;
	logic                  imm_ref_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			quad_r  <= '0;
			qhigh_r <= '0;
			qlow_r  <= '0;
		end else begin
			quad_r  <= {i_data_high_reg, i_accumulator_reg};
			qhigh_r <= i_quad_result[QUAD_W-1:ADDR_W];
			qlow_r  <= i_quad_result[ADDR_W-1:0];
		end
	end

	// Immediate field is 32 bits wide, so it cannot pass the doubleword range
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			imm_ref_r <= 1'b0;
		else
			imm_ref_r <= i_imm_valid && i_quotient_op;
	end

	assign o_quad_operand = quad_r;
	assign o_quad_high    = qhigh_r;
	assign o_quad_low     = qlow_r;
	assign o_imm_refused  = imm_ref_r;

	////////////////////////////////////////////////////////////////////////////
	// Independent wide reference sum for checking
	logic signed [39:0] chk_disp;
	logic signed [39:0] chk_sum;

	always_comb begin
		chk_disp = '0;
		if (i_disp_en) begin
			if (i_disp_w == OAG_DISP_8)
				chk_disp = 40'($signed(i_disp_val[7:0]));
			else if (i_disp_w == OAG_DISP_16)
				chk_disp = 40'($signed(i_disp_val[15:0]));
			else
				chk_disp = 40'($signed(i_disp_val));
		end
		chk_sum = chk_disp;
		if (i_base_en)
			chk_sum = chk_sum + 40'($signed(i_base_val));
		if (i_index_en && i_index_id != OAG_GPR_STACK)
			chk_sum = chk_sum + 40'($signed(i_index_val)) * (40'sh1 <<< i_scale);
	end

	property p_ea_sum;
		@(posedge i_clk) disable iff (i_reset)
		i_req_valid |=> o_valid && o_ea == $past(chk_sum[31:0]);
	endproperty
	a_ea_sum: assert property (p_ea_sum) else $error("EA sum mismatch");

	property p_idx_fault;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_index_en && i_index_id == OAG_GPR_STACK) |=> o_index_fault;
	endproperty
	a_idx_fault: assert property (p_idx_fault) else $error("Stack index not flagged");

	property p_fetch_seg;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_ref_kind == OAG_REF_FETCH) |=> o_seg == OAG_SEG_CODE;
	endproperty
	a_fetch_seg: assert property (p_fetch_seg) else $error("Fetch not on code seg");

	property p_push_seg;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_ref_kind == OAG_REF_PUSHPOP) ##1 o_valid |-> o_seg == OAG_SEG_STACK;
	endproperty
	a_push_seg: assert property (p_push_seg) else $error("Push/pop not on stack");

	property p_str_seg;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_ref_kind == OAG_REF_STR_DEST && i_ovr_en)
			|=> o_seg == OAG_SEG_STRING_TARGET;
	endproperty
	a_str_seg: assert property (p_str_seg) else $error("String dest overridden");

	property p_default_seg;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_ref_kind == OAG_REF_DATA && !i_ovr_en)
			|=> o_seg == ($past(i_base_en) && ($past(i_base_id) == OAG_GPR_STACK
				|| $past(i_base_id) == OAG_GPR_FRAME) ? OAG_SEG_STACK : OAG_SEG_DATA);
	endproperty
	a_default_seg: assert property (p_default_seg) else $error("Wrong default seg");

	property p_ovr_seg;
		@(posedge i_clk) disable iff (i_reset)
		(i_req_valid && i_ref_kind == OAG_REF_DATA && i_ovr_en) |=> o_seg == $past(i_ovr_seg);
	endproperty
	a_ovr_seg: assert property (p_ovr_seg) else $error("Override not applied");

	property p_far;
		@(posedge i_clk) disable iff (i_reset)
		i_far_valid |=> o_far_valid && {o_far_selector, o_far_offset} == $past(i_far_mem);
	endproperty
	a_far: assert property (p_far) else $error("Far pointer split wrong");

	property p_quad;
		@(posedge i_clk) disable iff (i_reset)
		1'b1 |=> o_quad_operand[63:32] == $past(i_data_high_reg)
			&& o_quad_low == $past(i_quad_result[31:0]);
	endproperty
	a_quad: assert property (p_quad) else $error("Register pair order wrong");

	property p_imm;
		@(posedge i_clk) disable iff (i_reset)
		(i_imm_valid && !i_quotient_op) |=> !o_imm_refused;
	endproperty
	a_imm: assert property (p_imm) else $error("Immediate wrongly refused");

	property p_sel;
		@(posedge i_clk) disable iff (i_reset)
		(i_sel_load && i_sel_from_reg) |=> o_sel_valid && o_sel_value == $past(i_sel_reg);
	endproperty
	a_sel: assert property (p_sel) else $error("Selector load wrong");

	property p_lane;
		@(posedge i_clk) disable iff (i_reset)
		i_req_valid |=> o_byte_addr[0] == o_ea && o_byte_data[0] == $past(i_store_data[7:0])
			&& o_byte_data[3] == $past(i_store_data[31:24]);
	endproperty
	a_lane: assert property (p_lane) else $error("Lowest byte misplaced");
endmodule : oag_top
`default_nettype wire

// ---- test/oag_decoder_model.sv ----
// Purpose: Decoder-side model presenting address requests
// Assumes: Requests launched just after a rising edge, taken at the next
// Notes:   Released value lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module oag_decoder_model
	import oag_pkg::*;
(
	input  wire logic          i_clk,
	output logic               o_req_valid,
	output oag_ref_t           o_ref_kind,
	output logic               o_base_en,
	output oag_gpr_t           o_base_id,
	output logic [ADDR_W-1:0]  o_base_val,
	output logic               o_index_en,
	output oag_gpr_t           o_index_id,
	output logic [ADDR_W-1:0]  o_index_val,
	output oag_scale_t         o_scale,
	output logic               o_disp_en,
	output oag_disp_t          o_disp_w,
	output logic [ADDR_W-1:0]  o_disp_val,
	output logic               o_ovr_en,
	output oag_seg_t           o_ovr_seg,
	output logic [ADDR_W-1:0]  o_store_data
);
	initial begin
		{o_req_valid, o_base_en, o_index_en, o_disp_en, o_ovr_en} = 5'h00;
		{o_base_val, o_index_val, o_disp_val, o_store_data} = 128'h0;
		o_ref_kind = OAG_REF_DATA;
		o_base_id = OAG_GPR_ACC;
		o_index_id = OAG_GPR_ACC;
		o_scale = OAG_SCALE_1;
		o_disp_w = OAG_DISP_32;
		o_ovr_seg = OAG_SEG_DATA;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic send(input oag_ref_t rk, input logic be, input oag_gpr_t bi,
		input logic [31:0] bv, input logic ie, input oag_gpr_t ii, input logic [31:0] iv,
		input oag_scale_t sc, input logic de, input oag_disp_t dw, input logic [31:0] dv,
		input logic oe, input oag_seg_t os, input logic [31:0] sd);
		@(posedge i_clk);
		o_req_valid <= 1'b1;
		o_ref_kind <= rk;
		o_base_en <= be;
		o_base_id <= bi;
		o_base_val <= bv;
		o_index_en <= ie;
		o_index_id <= ii;
		o_index_val <= iv;
		o_scale <= sc;
		o_disp_en <= de;
		o_disp_w <= dw;
		o_disp_val <= dv;
		o_ovr_en <= oe;
		o_ovr_seg <= os;
		o_store_data <= sd;
		@(posedge i_clk);
		o_req_valid <= 1'b0;
		o_base_val <= ~bv;
		o_index_val <= ~iv;
		o_disp_val <= ~dv;
		o_store_data <= ~sd;
	endtask : send
endmodule : oag_decoder_model
`default_nettype wire

// ---- test/operand_address_generator_test.sv ----
// Purpose: Self-checking bench of the operand address generator
// Assumes: Results appear one edge after each request
// Notes:   Expectations computed here from the address rules
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_test
	import oag_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, rv, be, ie, de, oe, sl, sfr, fv, iv_, qo;
	oag_ref_t rk;
	oag_gpr_t bi, ii;
	logic [31:0] bv, iv, dv, sd, dh, acc, ea, far_off, qh, ql;
	oag_scale_t sc;
	oag_disp_t dw;
	oag_seg_t os, seg, stg, sel_tg;
	logic [15:0] sm, sr, sel_val, far_sel;
	logic [47:0] fm;
	logic [63:0] qr, qop;
	logic [31:0] byte_addr [4];
	logic [7:0] byte_data [4];
	logic vld, flt, sel_v, far_v, refused;
	int err_count = 0, n_tests = 0;

	always #2 clk = ~clk;
	initial begin
		{sl, sfr, fv, iv_, qo} = 5'h00;
		{sm, sr, fm, dh, acc, qr} = 208'h0;
		stg = OAG_SEG_CODE;
	end

	oag_decoder_model oag_decoder_model_i (.i_clk(clk), .o_req_valid(rv), .o_ref_kind(rk),
		.o_base_en(be), .o_base_id(bi), .o_base_val(bv), .o_index_en(ie), .o_index_id(ii),
		.o_index_val(iv), .o_scale(sc), .o_disp_en(de), .o_disp_w(dw), .o_disp_val(dv),
		.o_ovr_en(oe), .o_ovr_seg(os), .o_store_data(sd));

	oag_top oag_top_i (.i_clk(clk), .i_reset(rst), .i_req_valid(rv), .i_ref_kind(rk),
		.i_base_en(be), .i_base_id(bi), .i_base_val(bv), .i_index_en(ie), .i_index_id(ii),
		.i_index_val(iv), .i_scale(sc), .i_disp_en(de), .i_disp_w(dw), .i_disp_val(dv),
		.i_ovr_en(oe), .i_ovr_seg(os), .i_store_data(sd), .i_sel_load(sl),
		.i_sel_from_reg(sfr), .i_sel_mem(sm), .i_sel_reg(sr), .i_sel_target(stg),
		.i_far_valid(fv), .i_far_mem(fm), .i_data_high_reg(dh), .i_accumulator_reg(acc),
		.i_quad_result(qr), .i_imm_valid(iv_), .i_quotient_op(qo), .o_valid(vld), .o_ea(ea),
		.o_seg(seg), .o_index_fault(flt), .o_byte_addr(byte_addr), .o_byte_data(byte_data),
		.o_sel_valid(sel_v), .o_sel_target(sel_tg), .o_sel_value(sel_val),
		.o_far_valid(far_v), .o_far_offset(far_off), .o_far_selector(far_sel),
		.o_quad_operand(qop), .o_quad_high(qh), .o_quad_low(ql), .o_imm_refused(refused));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic req(input oag_ref_t r, input logic b_en, input oag_gpr_t b_id,
		input logic [31:0] b_v, input logic i_en, input oag_gpr_t i_id, input logic [31:0] i_v,
		input oag_scale_t s_c, input logic d_en, input oag_disp_t d_w, input logic [31:0] d_v,
		input logic o_en, input oag_seg_t o_s);
		logic [31:0] e, d, data;
		logic f;
		oag_seg_t s;
		data = b_v ^ {i_v[15:0], d_v[15:0]} ^ 32'hA5C3_0F96;
		d = (d_w == OAG_DISP_8) ? {{24{d_v[7]}}, d_v[7:0]} :
			(d_w == OAG_DISP_16) ? {{16{d_v[15]}}, d_v[15:0]} : d_v;
		f = i_en && (i_id == OAG_GPR_STACK);
		e = (b_en ? b_v : 32'h0) + ((i_en && !f) ? i_v * (32'h1 << s_c) : 32'h0)
			+ (d_en ? d : 32'h0);
		case (r)
			OAG_REF_FETCH: s = OAG_SEG_CODE;
			OAG_REF_PUSHPOP: s = OAG_SEG_STACK;
			OAG_REF_STR_DEST: s = OAG_SEG_STRING_TARGET;
			default: s = o_en ? o_s : (b_en && (b_id == OAG_GPR_STACK || b_id == OAG_GPR_FRAME))
				? OAG_SEG_STACK : OAG_SEG_DATA;
		endcase
		oag_decoder_model_i.send(r, b_en, b_id, b_v, i_en, i_id, i_v, s_c, d_en, d_w, d_v,
			o_en, o_s, data);
		#1;
		chk("valid", vld, 1);
		chk("ea", ea, e);
		chk("index_fault", flt, f);
		chk("seg", seg, s);
		for (int k = 0; k < 4; k++) begin
			chk("byte_addr", byte_addr[k], 32'(e + k));
			chk("byte_data", byte_data[k], data[8*k +: 8]);
		end
	endtask : req

	////////////////////////////////////////////////////////////////////////////
	task automatic t_ea;
		req(OAG_REF_DATA, 1, OAG_GPR_ACC, 32'h1000, 1, OAG_GPR_CNT, 32'h10, OAG_SCALE_2,
			1, OAG_DISP_8, 32'h7777_77F0, 0, OAG_SEG_DATA);
		req(OAG_REF_DATA, 1, OAG_GPR_BASE, 32'h40000, 1, OAG_GPR_SRC, 32'hFFFF_FFFF,
			OAG_SCALE_4, 1, OAG_DISP_16, 32'h5555_8000, 0, OAG_SEG_DATA);
		req(OAG_REF_DATA, 0, OAG_GPR_ACC, 32'h5, 1, OAG_GPR_DST, 32'h3, OAG_SCALE_8,
			1, OAG_DISP_32, 32'h8765_4321, 0, OAG_SEG_DATA);
		req(OAG_REF_DATA, 0, OAG_GPR_ACC, 32'h7, 0, OAG_GPR_CNT, 32'h9, OAG_SCALE_8,
			0, OAG_DISP_32, 32'h11, 0, OAG_SEG_DATA);
		req(OAG_REF_DATA, 1, OAG_GPR_DHI, 32'hFFFF_FFF0, 0, OAG_GPR_CNT, 32'h1, OAG_SCALE_1,
			1, OAG_DISP_8, 32'h20, 0, OAG_SEG_DATA);
		req(OAG_REF_DATA, 1, OAG_GPR_ACC, 32'h200, 1, OAG_GPR_STACK, 32'h44, OAG_SCALE_2,
			0, OAG_DISP_8, 32'h0, 0, OAG_SEG_DATA);
		@(posedge clk);
		#1;
		chk("valid_end", vld, 0);
		chk("fault_end", flt, 0);
	endtask : t_ea

	task automatic t_seg;
		oag_gpr_t bl [3] = '{OAG_GPR_ACC, OAG_GPR_STACK, OAG_GPR_FRAME};
		for (int r = 0; r < 4; r++)
			for (int o = 0; o < 2; o++)
				for (int j = 0; j < 4; j++)
					req(oag_ref_t'(r), j < 3, j < 3 ? bl[j] : OAG_GPR_FRAME, 32'h100 * j, 0,
						OAG_GPR_CNT, 32'h0, OAG_SCALE_1, 1, OAG_DISP_32, 32'h10 * r,
						o[0], o[0] ? OAG_SEG_AUX1 : OAG_SEG_AUX0);
	endtask : t_seg

	task automatic t_sel_far;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			sl <= 1'b1;
			sfr <= m[0];
			sm <= 16'h1357;
			sr <= 16'hBEEF;
			stg <= m[0] ? OAG_SEG_AUX0 : OAG_SEG_DATA;
			fv <= 1'b1;
			fm <= m[0] ? 48'h9ABC_1234_5678 : 48'h0102_FEDC_BA98;
			@(posedge clk);
			sl <= 1'b0;
			fv <= 1'b0;
			sm <= 16'hECA8;
			sr <= 16'h4110;
			fm <= ~fm;
			#1;
			chk("sel_valid", sel_v, 1);
			chk("sel_value", sel_val, m[0] ? 16'hBEEF : 16'h1357);
			chk("sel_target", sel_tg, m[0] ? OAG_SEG_AUX0 : OAG_SEG_DATA);
			chk("far_valid", far_v, 1);
			chk("far_off", far_off, m[0] ? 32'h1234_5678 : 32'hFEDC_BA98);
			chk("far_sel", far_sel, m[0] ? 16'h9ABC : 16'h0102);
		end
	endtask : t_sel_far

	task automatic t_quad_imm;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			dh <= 32'hDEAD_0001 + m;
			acc <= 32'h0000_BEEF;
			qr <= 64'h0123_4567_89AB_CDEF << m;
			iv_ <= m[0];
			qo <= m[1];
			@(posedge clk);
			#1;
			chk("quad_op", qop, {32'hDEAD_0001 + m, 32'h0000_BEEF});
			chk("quad_hl", {qh, ql}, 64'h0123_4567_89AB_CDEF << m);
			chk("imm_refused", refused, m == 3);
		end
	endtask : t_quad_imm

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		chk("reset_seg", seg, OAG_SEG_DATA);
		chk("reset_valid", vld, 0);
		rst <= 1'b0;
		t_ea();
		t_seg();
		t_sel_far();
		t_quad_imm();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule : operand_address_generator_test
`default_nettype wire
